// *** design/rx_desc_pkg.sv ***
// Constants, types and layouts for the receive descriptor engine
// Function
// R1 - Set frame-oversize flag, status bit 7, when frame exceeds 1518 bytes.
// R2 - Oversize flag is valid in every descriptor of a multi-descriptor frame.
// R3 - Set late-collision flag, bit 6, for collision beyond 64 bytes after SFD.
// R4 - Set ethertype flag, bit 5, when length/type exceeds 1500; clear otherwise.
// R5 - Ethertype flag has no meaning for runt frames under 14 bytes.
// R6 - Set bit 3 when the PHY signals a receive error during the frame.
// R7 - Set dribble flag, bit 2, when frame did not end on a byte boundary.
// R8 - Set bit 1 when the frame check sequence fails the CRC check.
// R9 - CRC error flag is invalid for runt frames; host ignores it then.
// R10 - Collision, type, PHY, dribble and CRC flags meaningful only in last descriptor.
// R11 - Clear status bit 0 for every frame of legal length.
// R12 - Control bit 25 marks ring end; wrap to the list base address.
// R13 - Control bit 24 makes the second address the next-descriptor pointer.
// R14 - With ring end and chained both set, ring end wins.
// R15 - Host programs both buffer sizes as multiples of four bytes.
// R16 - Second buffer size zero: skip it and fetch the next descriptor.
// R17 - First buffer size zero: skip it and use the second buffer.
// R18 - Second buffer size honoured only while chained flag is clear.
// R19 - Host places a longword-aligned second buffer address in word 3.
// R20 - Clear ownership bit 31 when the frame completes or buffers are full.
// R21 - Set bit 8 in the descriptor holding the frame's final part.
// R22 - Write all status flags in the same write that clears ownership.
package rx_desc_pkg;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BASE = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_CUR = 8'h0C;
    localparam logic [7:0] REG_FRAMES = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int B_OWN = 31;
    localparam int B_FL_LSB = 16;
    localparam int FL_W = 14;
    localparam int B_FIRST = 9;
    localparam int B_LAST = 8;
    localparam int B_OVERSIZE = 7;
    localparam int B_LATE = 6;
    localparam int B_ETYPE = 5;
    localparam int B_PHY = 3;
    localparam int B_DRIB = 2;
    localparam int B_CRC = 1;
    localparam int B_LEN_BAD = 0;
    localparam int B_WRAP = 25;
    localparam int B_CHAIN = 24;
    localparam int BS2_LSB = 11;
    localparam int BS1_LSB = 0;
    localparam int BS_W = 11;
    localparam logic [15:0] MAX_FRAME = 16'h05EE;
    localparam logic [15:0] ETYPE_MIN = 16'h05DC;
    localparam logic [15:0] HDR_BYTES = 16'h000E;
    localparam logic [15:0] LT_HI_IDX = 16'h000C;
    localparam logic [15:0] LT_LO_IDX = 16'h000D;
    localparam logic [31:0] DESC_STEP = 32'h0000_0010;
    localparam logic [31:0] W1_OFF = 32'h0000_0004;
    localparam logic [31:0] W2_OFF = 32'h0000_0008;
    localparam logic [31:0] W3_OFF = 32'h0000_000C;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [1:0] LANE_LAST = 2'h3;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_RD0 = 4'h1, S_RD1 = 4'h2, S_RD2 = 4'h3, S_RD3 = 4'h4,
        S_DATA = 4'h5, S_WRD = 4'h6, S_WST = 4'h7, S_NEXT = 4'h8
    } st_t;
    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_cmd_t;
    typedef struct packed {
        logic late_coll;
        logic phy_err;
        logic dribble;
        logic crc_bad;
    } rx_end_t;
endpackage

// *** design/rx_descriptor_status_control.sv ***
// Receive descriptor engine with AXI4-Lite registers and memory master
`timescale 1ns/100ps
`default_nettype none
module rx_descriptor_status_control (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Descriptor and buffer memory master
    output logic mem_valid,
    output rx_desc_pkg::mem_cmd_t mem_cmd,
    input wire logic mem_ready,
    input wire logic [31:0] mem_rdata,
    // Received byte stream from the MAC
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire rx_desc_pkg::rx_end_t rx_end,
    output logic rx_ready
);
    import rx_desc_pkg::*;

    st_t state_ff, nxt_state;
    logic [31:0] cur_ff, nxt_cur, ctl_ff, nxt_ctl, b1_ff, nxt_b1, b2_ff, nxt_b2;
    logic [31:0] wptr_ff, nxt_wptr, word_ff, nxt_word, frames_ff, nxt_frames;
    logic [31:0] base_ff, enable_word;
    logic [BS_W-1:0] rem_ff, nxt_rem;
    logic [1:0] lane_ff, nxt_lane;
    logic [15:0] len_ff, nxt_len, lt_ff, nxt_lt;
    rx_end_t end_ff, nxt_end;
    logic two_ff, nxt_two, last_ff, nxt_last, inf_ff, nxt_inf, dfirst_ff, nxt_dfirst;
    logic enable_ff, mem_valid_ff, nxt_mem_valid, rx_ready_ff;
    mem_cmd_t mem_cmd_ff, nxt_mem_cmd;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, sw;

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr[7:2] == off[7:2]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    // Register bus decode
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
    wire wr_fire = awready_ff & s_axi_awvalid & s_axi_wvalid;
    wire rd_go = s_axi_arvalid & ~arready_ff & ~rvalid_ff;
    wire rd_fire = arready_ff & s_axi_arvalid;
    wire hit_ctrl_w = reg_hit(s_axi_awaddr, REG_CTRL);
    wire hit_base_w = reg_hit(s_axi_awaddr, REG_BASE);
    wire wr_ok = hit_ctrl_w | hit_base_w;
    wire base_we = wr_fire & hit_base_w;
    wire ctrl_we = wr_fire & hit_ctrl_w;
    wire [31:0] base_merged = merge(base_ff, s_axi_wdata, s_axi_wstrb);
    wire [31:0] base_new = {base_merged[31:2], 2'b00};
    wire hit_ctrl_r = reg_hit(s_axi_araddr, REG_CTRL);
    wire hit_base_r = reg_hit(s_axi_araddr, REG_BASE);
    wire hit_stat_r = reg_hit(s_axi_araddr, REG_STAT);
    wire hit_cur_r = reg_hit(s_axi_araddr, REG_CUR);
    wire hit_frm_r = reg_hit(s_axi_araddr, REG_FRAMES);
    wire rd_ok = hit_ctrl_r | hit_base_r | hit_stat_r | hit_cur_r | hit_frm_r;
    wire [31:0] stat_word = {23'h000000, inf_ff, two_ff, last_ff, 2'b00, state_ff};
    wire [31:0] rd_mux = hit_ctrl_r ? enable_word :
                         hit_base_r ? base_ff :
                         hit_stat_r ? stat_word :
                         hit_cur_r ? cur_ff :
                         hit_frm_r ? frames_ff : 32'h0000_0000;
    assign enable_word = {31'h00000000, enable_ff};

    // Descriptor fields
    wire [BS_W-1:0] bs1 = ctl_ff[BS1_LSB +: BS_W];
    wire [BS_W-1:0] bs2 = ctl_ff[BS2_LSB +: BS_W];
    wire chain = ctl_ff[B_CHAIN];
    wire wrap = ctl_ff[B_WRAP];
    wire [BS_W-1:0] bs2_eff = chain ? '0 : bs2; // R18
    wire mem_done = mem_valid_ff & mem_ready;
    wire is_mem = (state_ff == S_RD0) | (state_ff == S_RD1) | (state_ff == S_RD2) |
                  (state_ff == S_RD3) | (state_ff == S_WRD) | (state_ff == S_WST);
    wire take = (state_ff == S_DATA) & rx_valid;
    wire [31:0] next_seq = cur_ff + DESC_STEP;
    wire [31:0] next_desc = wrap ? base_ff : (chain ? b2_ff : next_seq); // R12 R13 R14
    wire [BS_W-1:0] word_bytes = WORD_BYTES[BS_W-1:0];

    // Status word, written in one go with ownership cleared
    always_comb begin
        sw = 32'h0000_0000;
        sw[B_OWN] = 1'b0; // R20 R22
        sw[B_FIRST] = dfirst_ff;
        sw[B_LAST] = last_ff; // R21
        sw[B_OVERSIZE] = (len_ff > MAX_FRAME); // R1 R2
        sw[B_LEN_BAD] = 1'b0; // R11
        if (last_ff) begin // R10
            sw[B_LATE] = end_ff.late_coll; // R3
            sw[B_ETYPE] = (lt_ff > ETYPE_MIN) & (len_ff >= HDR_BYTES); // R4 R5
            sw[B_PHY] = end_ff.phy_err; // R6
            sw[B_DRIB] = end_ff.dribble; // R7
            // Written even for runts; host discards it there
            sw[B_CRC] = end_ff.crc_bad; // R8 R9
            sw[B_FL_LSB +: FL_W] = len_ff[FL_W-1:0];
        end
    end

    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cur = cur_ff;
        nxt_ctl = ctl_ff;
        nxt_b1 = b1_ff;
        nxt_b2 = b2_ff;
        nxt_wptr = wptr_ff;
        nxt_rem = rem_ff;
        nxt_two = two_ff;
        nxt_word = word_ff;
        nxt_lane = lane_ff;
        nxt_len = len_ff;
        nxt_lt = lt_ff;
        nxt_end = end_ff;
        nxt_last = last_ff;
        nxt_inf = inf_ff;
        nxt_dfirst = dfirst_ff;
        nxt_frames = frames_ff;
        case (state_ff)
            S_IDLE: begin
                // Polls the current descriptor while enabled
                if (enable_ff) begin
                    nxt_state = S_RD0;
                end
            end
            S_RD0: begin
                if (mem_done) begin
                    nxt_state = mem_rdata[B_OWN] ? S_RD1 : S_IDLE;
                end
            end
            S_RD1: begin
                if (mem_done) begin
                    nxt_ctl = mem_rdata;
                    nxt_state = S_RD2;
                end
            end
            S_RD2: begin
                if (mem_done) begin
                    nxt_b1 = mem_rdata;
                    nxt_state = S_RD3;
                end
            end
            S_RD3: begin
                if (mem_done) begin
                    nxt_b2 = mem_rdata;
                    nxt_dfirst = ~inf_ff;
                    if (bs1 != '0) begin
                        nxt_wptr = b1_ff;
                        nxt_rem = bs1;
                        nxt_two = 1'b0;
                        nxt_state = S_DATA;
                    end else if (bs2_eff != '0) begin // R17
                        nxt_wptr = mem_rdata;
                        nxt_rem = bs2_eff;
                        nxt_two = 1'b1;
                        nxt_state = S_DATA;
                    end else begin // R16
                        nxt_state = S_NEXT;
                    end
                end
            end
            S_DATA: begin
                if (rx_valid) begin
                    nxt_word[{lane_ff, 3'b000} +: 8] = rx_data;
                    nxt_lane = lane_ff + 2'h1;
                    nxt_len = len_ff + 16'h0001;
                    nxt_inf = 1'b1;
                    if (len_ff == LT_HI_IDX) begin
                        nxt_lt[15:8] = rx_data;
                    end
                    if (len_ff == LT_LO_IDX) begin
                        nxt_lt[7:0] = rx_data;
                    end
                    if (rx_last) begin
                        nxt_end = rx_end;
                        nxt_last = 1'b1;
                    end
                    if (rx_last || lane_ff == LANE_LAST) begin
                        nxt_state = S_WRD;
                    end
                end
            end
            S_WRD: begin
                if (mem_done) begin
                    // Buffers assumed whole words at aligned addresses
                    nxt_wptr = wptr_ff + WORD_BYTES; // R15 R19
                    nxt_rem = (rem_ff > word_bytes) ? rem_ff - word_bytes : '0;
                    nxt_lane = 2'h0;
                    if (last_ff) begin
                        nxt_state = S_WST;
                    end else if (rem_ff <= word_bytes) begin
                        if (!two_ff && bs2_eff != '0) begin
                            nxt_wptr = b2_ff;
                            nxt_rem = bs2_eff;
                            nxt_two = 1'b1;
                            nxt_state = S_DATA;
                        end else begin // R20
                            nxt_state = S_WST;
                        end
                    end else begin
                        nxt_state = S_DATA;
                    end
                end
            end
            S_WST: begin
                if (mem_done) begin
                    if (last_ff) begin
                        nxt_last = 1'b0;
                        nxt_inf = 1'b0;
                        nxt_len = 16'h0000;
                        nxt_lt = 16'h0000;
                        nxt_frames = frames_ff + 32'h0000_0001;
                    end
                    nxt_state = S_NEXT;
                end
            end
            S_NEXT: begin
                nxt_cur = next_desc; // R12 R13 R14
                nxt_state = enable_ff ? S_RD0 : S_IDLE;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
        // Software moving the list base restarts the walk there
        if (base_we) begin
            nxt_cur = base_new;
        end
    end

    // Memory command, held until taken
    wire [31:0] rd_addr = (state_ff == S_RD1) ? cur_ff + W1_OFF :
                          (state_ff == S_RD2) ? cur_ff + W2_OFF :
                          (state_ff == S_RD3) ? cur_ff + W3_OFF : cur_ff;
    wire wr_data = (state_ff == S_WRD);
    wire issue = ~mem_valid_ff & is_mem;
    always_comb begin
        nxt_mem_valid = mem_valid_ff;
        nxt_mem_cmd = mem_cmd_ff;
        if (mem_done) begin
            nxt_mem_valid = 1'b0;
        end else if (issue) begin
            nxt_mem_valid = 1'b1;
            nxt_mem_cmd.we = wr_data | (state_ff == S_WST);
            nxt_mem_cmd.addr = wr_data ? wptr_ff : rd_addr;
            nxt_mem_cmd.wdata = wr_data ? word_ff : sw; // R22
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= S_IDLE;
            {cur_ff, ctl_ff, b1_ff, b2_ff, wptr_ff, word_ff, frames_ff} <= '0;
            {rem_ff, lane_ff, len_ff, lt_ff, end_ff} <= '0;
            {two_ff, last_ff, inf_ff, dfirst_ff, mem_valid_ff, rx_ready_ff} <= '0;
            mem_cmd_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            {cur_ff, ctl_ff, b1_ff, b2_ff} <= {nxt_cur, nxt_ctl, nxt_b1, nxt_b2};
            {wptr_ff, word_ff, frames_ff} <= {nxt_wptr, nxt_word, nxt_frames};
            {rem_ff, lane_ff, len_ff, lt_ff, end_ff} <= {nxt_rem, nxt_lane, nxt_len, nxt_lt, nxt_end};
            {two_ff, last_ff, inf_ff, dfirst_ff} <= {nxt_two, nxt_last, nxt_inf, nxt_dfirst};
            mem_valid_ff <= nxt_mem_valid;
            mem_cmd_ff <= nxt_mem_cmd;
            // Registered copy of the DATA decode, so the pin has no decode glitches
            rx_ready_ff <= (nxt_state == S_DATA);
        end
    end

    // Register slave; ready is registered, so each access costs a turn
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff} <= '0;
            {bresp_ff, rresp_ff} <= '0;
            rdata_ff <= '0;
            base_ff <= '0;
            enable_ff <= 1'b0;
        end else begin
            awready_ff <= wr_go;
            wready_ff <= wr_go;
            arready_ff <= rd_go;
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
            if (base_we) begin
                base_ff <= base_new;
            end
            if (ctrl_we && s_axi_wstrb[0]) begin
                enable_ff <= s_axi_wdata[0];
            end
        end
    end

    assign {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} = {awready_ff, wready_ff, bvalid_ff, bresp_ff};
    assign {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp} = {arready_ff, rvalid_ff, rdata_ff, rresp_ff};
    assign mem_valid = mem_valid_ff;
    assign mem_cmd = mem_cmd_ff;
    assign rx_ready = rx_ready_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire wst_done = (state_ff == S_WST) & mem_done;
    wire [31:0] wd = mem_cmd_ff.wdata;
    sequence s_last_byte;
        take && rx_last;
    endsequence
    sequence s_first_empty;
        (state_ff == S_RD3) && mem_done && (bs1 == '0);
    endsequence

    a_own_returned: assert property (wst_done |-> !wd[B_OWN] && mem_cmd_ff.we) else $error("ownership kept"); // R20 R22
    a_oversize_flag: assert property (wst_done |-> wd[B_OVERSIZE] == (len_ff > MAX_FRAME)) else $error("oversize"); // R1 R2
    a_zero_bit: assert property (wst_done |-> !wd[B_LEN_BAD]) else $error("bit zero set"); // R11
    a_nonlast_quiet: assert property (wst_done && !last_ff |-> wd[B_LATE:B_CRC] == '0) else $error("flags leak"); // R10
    a_crc_phy: assert property (wst_done && last_ff |-> wd[B_CRC] == end_ff.crc_bad && wd[B_PHY] == end_ff.phy_err)
        else $error("crc or phy flag"); // R8 R6 R9
    a_late_drib: assert property (wst_done && last_ff |-> wd[B_LATE] == end_ff.late_coll && wd[B_DRIB] == end_ff.dribble)
        else $error("late or dribble flag"); // R3 R7
    a_etype_runt: assert property (wst_done && len_ff < HDR_BYTES |-> !wd[B_ETYPE]) else $error("type on runt"); // R4 R5
    a_last_marked: assert property (s_last_byte |=> last_ff && state_ff == S_WRD ##1 last_ff) else $error("last lost"); // R21
    a_wrap_base: assert property (state_ff == S_NEXT && wrap && !base_we |=> cur_ff == $past(base_ff))
        else $error("no wrap"); // R12 R14
    a_chain_next: assert property (state_ff == S_NEXT && !wrap && chain && !base_we |=> cur_ff == $past(b2_ff))
        else $error("no chain"); // R13
    a_skip_first: assert property (s_first_empty and (bs2_eff != '0) |=> two_ff && state_ff == S_DATA)
        else $error("first not skipped"); // R17
    a_chain_size: assert property (s_first_empty and chain |=> state_ff == S_NEXT) else $error("size used"); // R18 R16
endmodule
`default_nettype wire

// *** sim/desc_mem_model.sv ***
// Behavioural descriptor and buffer memory on the far side of the engine
`timescale 1ns/100ps
`default_nettype none
module desc_mem_model
    import rx_desc_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Memory slave
    input wire logic mem_valid,
    input wire rx_desc_pkg::mem_cmd_t mem_cmd,
    output logic mem_ready,
    output logic [31:0] mem_rdata,
    // Answer latency in cycles
    input wire logic [3:0] lat
);
    logic [31:0] mem [0:4095];
    logic [31:0] last_ff;
    logic [3:0] wait_ff;
    wire logic [11:0] idx = mem_cmd.addr[13:2];
    assign mem_ready = mem_valid && (wait_ff >= lat);
    // Idle data shows the inverse of the last word, so stale data never passes
    assign mem_rdata = (mem_ready && !mem_cmd.we) ? mem[idx] : ~last_ff;
    initial begin
        last_ff = 32'h0;
        wait_ff = 4'h0;
        for (int i = 0; i < 4096; i++) mem[i] = 32'h0;
    end
    always @(posedge aclk) begin
        wait_ff <= (mem_valid && !mem_ready) ? wait_ff + 4'h1 : 4'h0;
        if (mem_ready) begin
            last_ff <= mem_cmd.we ? mem_cmd.wdata : mem_rdata;
            if (mem_cmd.we) mem[idx] <= mem_cmd.wdata;
        end
    end
endmodule
`default_nettype wire

// *** sim/rx_descriptor_status_control_bench.sv ***
// Self-checking bench for the receive descriptor engine
`timescale 1ns/100ps
`default_nettype none
module rx_descriptor_status_control_bench;
    import rx_desc_pkg::*;
    typedef struct packed {logic [15:0] len; logic [15:0] lt; logic [3:0] ev; logic [31:0] st;} row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, mem_rdata;
    logic [3:0] s_axi_wstrb, lat;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic mem_valid, mem_ready, rx_valid, rx_last, rx_ready;
    mem_cmd_t mem_cmd;
    rx_end_t rx_end;
    int miscompares = 0;
    int n_checks = 0;
    // Length, length/type, end flags {late, phy, dribble, crc}, expected status
    row_t rows [5] = '{'{16'h0040, 16'h0800, 4'h0, 32'h0040_0320}, '{16'h003C, 16'h05DC, 4'h1, 32'h003C_0302},
        '{16'h05EF, 16'h05DD, 4'h8, 32'h05EF_03E0}, '{16'h05EE, 16'h0600, 4'h6, 32'h05EE_032C},
        '{16'h000D, 16'h0800, 4'h1, 32'h000D_0302}};
    rx_descriptor_status_control u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .mem_valid(mem_valid), .mem_cmd(mem_cmd), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_end(rx_end), .rx_ready(rx_ready));
    desc_mem_model u_mem (.aclk(aclk), .mem_valid(mem_valid), .mem_cmd(mem_cmd), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .lat(lat));
    task automatic test_done;
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
    endtask
    // Bytes count up, except the length/type pair at offsets 12 and 13
    task automatic send(input int len, input logic [15:0] lt, input logic [3:0] ev);
        @(posedge aclk);
        for (int i = 0; i < len; i++) begin
            rx_valid <= 1'b1;
            rx_data <= (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : 8'(i);
            rx_last <= (i == len - 1);
            rx_end <= (i == len - 1) ? rx_end_t'(ev) : rx_end_t'(4'h0);
            do @(posedge aclk); while (rx_ready !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_end <= rx_end_t'(4'h0);
    endtask
    task automatic wait_own(input int w);
        do @(posedge aclk); while (u_mem.mem[w][31] !== 1'b0);
    endtask
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Whole run needs roughly 9k cycles; 60k leaves margin for slow memory
    initial begin
        #6_000_000;
        miscompares++;
        test_done;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, rx_data, rx_valid, rx_last} = 26'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        rx_end = rx_end_t'(4'h0);
        lat = 4'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(REG_CTRL, 32'h0, RESP_OKAY);
        axw(REG_BASE, 32'h0000_0103, RESP_OKAY);
        axr(REG_BASE, 32'h0000_0100, RESP_OKAY);
        axw(8'h14, 32'h1, RESP_SLVERR);
        axr(8'h14, 32'h0, RESP_SLVERR);
        // Single ring-end descriptor, buffer one empty, buffer two at 0x1000
        u_mem.mem[1] = 32'h023F_E000;
        u_mem.mem[2] = 32'h0000_2000;
        u_mem.mem[3] = 32'h0000_1000;
        axw(REG_BASE, 32'h0, RESP_OKAY);
        axw(REG_CTRL, 32'h1, RESP_OKAY);
        foreach (rows[k]) begin
            @(negedge aclk);
            u_mem.mem[0] = 32'h8000_0000;
            send(int'(rows[k].len), rows[k].lt, rows[k].ev);
            wait_own(0);
            chk(u_mem.mem[0], rows[k].st);
        end
        chk(u_mem.mem[12'h400], 32'h0302_0100);
        chk(u_mem.mem[12'h800], 32'h0);
        axr(REG_FRAMES, 32'h5, RESP_OKAY);
        // Frame split over a chained pair; second has ring end and chain both set
        lat = 4'h3;
        u_mem.mem[1] = 32'h0108_05F0;
        u_mem.mem[2] = 32'h0000_1000;
        u_mem.mem[3] = 32'h0000_0020;
        // Chained descriptor with no first buffer; its second size must be ignored
        u_mem.mem[8] = 32'h8000_0000;
        u_mem.mem[9] = 32'h0100_2000;
        u_mem.mem[11] = 32'h0000_0040;
        u_mem.mem[16] = 32'h8000_0000;
        u_mem.mem[17] = 32'h0300_0200;
        u_mem.mem[18] = 32'h0000_3000;
        u_mem.mem[19] = 32'h0000_0080;
        @(negedge aclk);
        u_mem.mem[0] = 32'h8000_0000;
        send(1600, 16'h0800, 4'h8);
        wait_own(16);
        chk(u_mem.mem[0], 32'h0000_0280);
        chk(u_mem.mem[16], 32'h0640_01E0);
        chk(u_mem.mem[8], 32'h8000_0000);
        chk(u_mem.mem[12'hC00], 32'hF3F2_F1F0);
        axr(REG_CUR, 32'h0, RESP_OKAY);
        axr(REG_FRAMES, 32'h6, RESP_OKAY);
        // Reset in mid-run while the engine polls
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(REG_CTRL, 32'h0, RESP_OKAY);
        axr(REG_STAT, 32'h0, RESP_OKAY);
        axr(REG_FRAMES, 32'h0, RESP_OKAY);
        test_done;
    end
endmodule
`default_nettype wire
